// [core/register_protect_and_status.sv]
`default_nettype none
module register_protect_and_status (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial register port
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regAck,
  // command hand-off
  output logic cmdValid,
  output logic [7:0] cmdCode,
  input wire logic absReinitDone,
  input wire logic softRestartDone,
  // signal path conditions
  input wire logic noniusClip,
  input wire logic noniusLowLevel,
  input wire logic masterClip,
  input wire logic masterLowLevel,
  input wire logic quadratureOverspeed,
  input wire logic converterOverspeed,
  // startup and memory conditions
  input wire logic startupBusFault,
  input wire logic checksumFault,
  input wire logic eepromFault,
  input wire logic commandRunning,
  // turn link conditions
  input wire logic turnLinkActive,
  input wire logic turnCommFail,
  input wire logic turnSsiError,
  input wire logic turnReadStart,
  input wire logic turnLastClock,
  input wire logic turnDataLine,
  input wire logic turnCountMismatch,
  input wire logic periodCountMismatch,
  // protection and engine state
  output logic openAccess,
  output logic eepromCmdAllowed,
  output logic engineHalt
);

  logic [7:0] store [0:encoder_regs_pkg::STORE_DEPTH-1];
  logic startupLatch;
  logic turnLinkFault;
  logic turnDataSync;
  logic [3:0] heldLow;
  logic [5:0] heldHigh;
  logic [7:0] next_rdata;

  // the data line is a pin: synchronise before any decision
  signal_sync u_turn_data_sync (
    .mclk(mclk),
    .rst(rst),
    .asyncIn(turnDataLine),
    .syncOut(turnDataSync)
  );

  // protection level decode
  wire logic [7:0] protByte = store[encoder_regs_pkg::ADDR_PROT_LEVEL[6:0]];
  wire logic [1:0] levelBits = protByte[encoder_regs_pkg::PROT_MSB:encoder_regs_pkg::PROT_LSB];
  wire logic restricted = levelBits != encoder_regs_pkg::LEVEL_CONFIG;
  wire logic unlockable = (levelBits == encoder_regs_pkg::LEVEL_SHIP_BUS)
    || (levelBits == encoder_regs_pkg::LEVEL_SHIP_NOBUS);
  wire logic busCmdOk = (levelBits == encoder_regs_pkg::LEVEL_CONFIG)
    || (levelBits == encoder_regs_pkg::LEVEL_SHIP_BUS);
  wire logic latchSelect =
    store[encoder_regs_pkg::ADDR_STATUS_CFG[6:0]][encoder_regs_pkg::LATCH_SELECT_BIT];
  wire logic [7:0] turnCfg = store[encoder_regs_pkg::ADDR_TURN_CFG[6:0]];
  wire logic [1:0] ssiMode = turnCfg[encoder_regs_pkg::SSI_MODE_MSB:encoder_regs_pkg::SSI_MODE_LSB];
  wire logic ampStopEnable = turnCfg[encoder_regs_pkg::AMP_STOP_BIT];

  // section decode
  wire logic inStore = regAddr < encoder_regs_pkg::STORE_TOP;
  wire logic inConf = regAddr < encoder_regs_pkg::EDS_BASE;
  wire logic inEds = (regAddr >= encoder_regs_pkg::EDS_BASE)
    && (regAddr < encoder_regs_pkg::USER_BASE);
  wire logic isUnlock = regAddr == encoder_regs_pkg::ADDR_UNLOCK;
  wire logic [6:0] storeIdx = regAddr[6:0];

  wire logic writeReq = regReq && regWrite;
  wire logic readReq = regReq && !regWrite;

  // unlock register stays writable so that a restricted part can be opened again
  wire logic writeOk = writeReq && inStore
    && (!restricted || isUnlock || !(inConf || inEds));
  wire logic readDenied = restricted && inConf;
  wire logic unlockHit = writeReq && isUnlock && unlockable
    && (regWdata == protByte);

  // command register writes
  wire logic cmdWriteReq = writeReq && (regAddr == encoder_regs_pkg::ADDR_COMMAND);
  wire logic cmdRefused = (regWdata == encoder_regs_pkg::CMD_EEPROM_BUS) && !busCmdOk;

  // startup fault sources
  wire logic ampHalt = masterLowLevel && ampStopEnable;
  wire logic turnStartupFault = turnLinkActive && (turnCommFail || turnSsiError);
  wire logic startupLive = startupLatch || ampHalt || turnStartupFault;

  // turn link fault events
  wire logic ssiModeHonoured = (ssiMode == encoder_regs_pkg::SSI_MODE_A)
    || (ssiMode == encoder_regs_pkg::SSI_MODE_B);
  wire logic turnFaultEvent = (turnReadStart && !turnDataSync)
    || (turnLastClock && turnDataSync)
    || (turnSsiError && ssiModeHonoured);

  // live status
  wire logic [4:0] liveLow = {startupLive, noniusClip, noniusLowLevel,
    masterClip, masterLowLevel};
  wire logic [5:0] liveHighAcc = {checksumFault, turnLinkFault, turnCountMismatch,
    periodCountMismatch, quadratureOverspeed, converterOverspeed};

  // clear requests: reads in accumulated mode, or the reinit and restart commands
  wire logic clearAddrHit = (regAddr == encoder_regs_pkg::ADDR_CLEAR_A)
    || (regAddr == encoder_regs_pkg::ADDR_CLEAR_B);
  wire logic clearLow = (readReq && latchSelect
    && (clearAddrHit || regAddr == encoder_regs_pkg::ADDR_STATUS_LOW))
    || absReinitDone || softRestartDone;
  wire logic clearHigh = (readReq && latchSelect
    && (clearAddrHit || regAddr == encoder_regs_pkg::ADDR_STATUS_HIGH))
    || absReinitDone || softRestartDone;

  status_accumulate #(
    .WIDTH(4)
  ) u_acc_low (
    .mclk(mclk),
    .rst(rst),
    .liveBits(liveLow[3:0]),
    .clearReq(clearLow),
    .heldBits(heldLow)
  );

  status_accumulate #(
    .WIDTH(6)
  ) u_acc_high (
    .mclk(mclk),
    .rst(rst),
    .liveBits(liveHighAcc),
    .clearReq(clearHigh),
    .heldBits(heldHigh)
  );

  // held copy ored with live so a fresh event is visible at once
  wire logic [3:0] shownLowAcc = latchSelect ? (heldLow | liveLow[3:0]) : liveLow[3:0];
  wire logic [5:0] shownHighAcc = latchSelect ? (heldHigh | liveHighAcc) : liveHighAcc;
  wire logic [7:0] statusLow = {3'b000, startupLive, shownLowAcc};
  wire logic [7:0] statusHigh = {shownHighAcc[5], eepromFault, shownHighAcc[4:0],
    commandRunning};

  // read data select; status needs no state to answer, so reads never stall
  always_comb begin
    next_rdata = encoder_regs_pkg::DENIED_READ_VALUE;
    if (regAddr == encoder_regs_pkg::ADDR_STATUS_LOW) begin
      next_rdata = statusLow;
    end else if (regAddr == encoder_regs_pkg::ADDR_STATUS_HIGH) begin
      next_rdata = statusHigh;
    end else if (inStore && !readDenied) begin
      next_rdata = store[storeIdx];
    end
  end

  // register store; unlock clears the level after the ordinary write
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < encoder_regs_pkg::STORE_DEPTH; i++) begin
        store[i] <= encoder_regs_pkg::STORE_RESET;
      end
    end else begin
      if (writeOk) begin
        store[storeIdx] <= regWdata;
      end
      if (unlockHit) begin
        store[encoder_regs_pkg::ADDR_PROT_LEVEL[6:0]][encoder_regs_pkg::PROT_MSB:
          encoder_regs_pkg::PROT_LSB] <= encoder_regs_pkg::LEVEL_CONFIG;
      end
    end
  end

  // register port answer, one cycle after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      regAck <= 1'b0;
      regRdata <= encoder_regs_pkg::DENIED_READ_VALUE;
    end else begin
      regAck <= regReq;
      if (readReq) begin
        regRdata <= next_rdata;
      end
    end
  end

  // command hand-off; a refused bus command never leaves the block
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmdValid <= 1'b0;
      cmdCode <= encoder_regs_pkg::CMD_RESET;
    end else begin
      cmdValid <= cmdWriteReq && !cmdRefused;
      if (cmdWriteReq && !cmdRefused) begin
        cmdCode <= regWdata;
      end
    end
  end

  // startup fault latch: set wins over the reinit that clears it
  always_ff @(posedge mclk) begin
    if (rst) begin
      startupLatch <= 1'b0;
    end else if (startupBusFault) begin
      startupLatch <= 1'b1;
    end else if (absReinitDone) begin
      startupLatch <= 1'b0;
    end
  end

  // turn link fault holds until the next clean read starts
  always_ff @(posedge mclk) begin
    if (rst) begin
      turnLinkFault <= 1'b0;
    end else if (turnFaultEvent) begin
      turnLinkFault <= 1'b1;
    end else if (turnReadStart) begin
      turnLinkFault <= 1'b0;
    end
  end

  // protection and engine state outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      openAccess <= 1'b1;
      eepromCmdAllowed <= 1'b1;
      engineHalt <= 1'b0;
    end else begin
      openAccess <= !restricted;
      eepromCmdAllowed <= busCmdOk;
      engineHalt <= startupLatch || ampHalt;
    end
  end

endmodule // register_protect_and_status
`default_nettype wire

// [core/encoder_regs_pkg.sv]
`default_nettype none
package encoder_regs_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] ADDR_STATUS_CFG = 8'h0D;
  localparam logic [7:0] ADDR_TURN_CFG = 8'h0E;
  localparam logic [7:0] ADDR_PROT_LEVEL = 8'h17;
  localparam logic [7:0] ADDR_CLEAR_A = 8'h3D;
  localparam logic [7:0] ADDR_CLEAR_B = 8'h3E;
  localparam logic [7:0] ADDR_UNLOCK = 8'h5A;
  localparam logic [7:0] ADDR_COMMAND = 8'h75;
  localparam logic [7:0] ADDR_STATUS_LOW = 8'h76;
  localparam logic [7:0] ADDR_STATUS_HIGH = 8'h77;

  // section boundaries
  localparam logic [7:0] EDS_BASE = 8'h40;
  localparam logic [7:0] USER_BASE = 8'h60;
  localparam logic [7:0] STORE_TOP = 8'h70;
  localparam int STORE_DEPTH = 112;

  // field positions
  localparam int PROT_MSB = 7;
  localparam int PROT_LSB = 6;
  localparam int LATCH_SELECT_BIT = 7;
  localparam int SSI_MODE_MSB = 1;
  localparam int SSI_MODE_LSB = 0;
  localparam int AMP_STOP_BIT = 2;

  // values after reset and fixed answers
  localparam logic [7:0] STORE_RESET = 8'h00;
  localparam logic [7:0] DENIED_READ_VALUE = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // command codes
  localparam logic [7:0] CMD_ABS_REINIT = 8'h03;
  localparam logic [7:0] CMD_SOFT_RESTART = 8'h07;
  localparam logic [7:0] CMD_EEPROM_BUS = 8'h0A;

  // link mode codes that honour the remote error bit
  localparam logic [1:0] SSI_MODE_A = 2'h1;
  localparam logic [1:0] SSI_MODE_B = 2'h3;

  typedef enum logic [1:0] {
    LEVEL_CONFIG = 2'b00,
    LEVEL_SHIP_LOCKED = 2'b01,
    LEVEL_SHIP_BUS = 2'b10,
    LEVEL_SHIP_NOBUS = 2'b11
  } protection_level_t;

endpackage
`default_nettype wire

// [core/signal_sync.sv]
`default_nettype none
module signal_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // asynchronous level in, synchronised level out
  input wire logic asyncIn,
  output logic syncOut
);

  logic firstStage;

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      firstStage <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      firstStage <= asyncIn;
      syncOut <= firstStage;
    end
  end

endmodule // signal_sync
`default_nettype wire

// [core/status_accumulate.sv]
`default_nettype none
module status_accumulate #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // live conditions and clear request
  input wire logic [WIDTH-1:0] liveBits,
  input wire logic clearReq,
  // accumulated copy
  output logic [WIDTH-1:0] heldBits
);

  // on clear the held copy takes the live value, so a same-cycle event survives
  always_ff @(posedge mclk) begin
    if (rst) begin
      heldBits <= '0;
    end else if (clearReq) begin
      heldBits <= liveBits;
    end else begin
      heldBits <= heldBits | liveBits;
    end
  end

endmodule // status_accumulate
`default_nettype wire

// [test/status_checker.sv]
`default_nettype none
module status_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regAck,
  // commands and state
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic openAccess,
  input wire logic eepromCmdAllowed,
  input wire logic engineHalt,
  // conditions
  input wire logic startupBusFault,
  input wire logic eepromFault,
  input wire logic commandRunning
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic cmdWr = regReq && regWrite && regAddr == encoder_regs_pkg::ADDR_COMMAND;
  wire logic stRd = regReq && !regWrite && regAddr == encoder_regs_pkg::ADDR_STATUS_HIGH;
  a_ack_follows: assert property (regReq |=> regAck) else $error("no answer");
  a_ack_only: assert property (!regReq |=> !regAck) else $error("stray answer");
  a_cmd_pass: assert property (
    cmdValid |-> $past(cmdWr) && cmdCode == $past(regWdata)) else $error("bad command");
  a_bus_refused: assert property (
    cmdWr && regWdata == encoder_regs_pkg::CMD_EEPROM_BUS && !eepromCmdAllowed |=> !cmdValid)
    else $error("bus command passed");
  a_open_bus: assert property (openAccess |-> eepromCmdAllowed) else $error("open no bus");
  a_lock_holds: assert property (
    !openAccess && !(regReq && regWrite) && !$past(regReq && regWrite) |=> !openAccess)
    else $error("lock dropped");
  // the latch and the registered halt add one flop each
  a_halt_set: assert property (startupBusFault |-> ##2 engineHalt) else $error("no halt");
  a_live_bits: assert property (
    stRd |=> regRdata[6] == $past(eepromFault) && regRdata[0] == $past(commandRunning))
    else $error("live bits wrong");
  c_unlock: cover property ($rose(openAccess));
  c_command: cover property (cmdValid);
  c_halt: cover property ($rose(engineHalt));
endmodule // status_checker
bind register_protect_and_status status_checker chk (.*);
`default_nettype wire

// [test/reg_host.sv]
`default_nettype none
module reg_host (
  // clock
  input wire logic mclk,
  // register port
  output logic regReq,
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regAck
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    regReq = 0;
    regWrite = 0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    @(negedge mclk);
    regReq = 1;
    regWrite = w;
    regAddr = a;
    regWdata = d;
    @(negedge mclk);
    regReq = 0;
    // idle lines flipped so a stale request never looks valid
    regAddr = ~a;
    regWdata = ~d;
    ok = regAck;
    q = regRdata;
  endtask
  // the key is the byte held at the level register
  task automatic unlock(input logic [7:0] stored, output logic ok);
    logic [7:0] q;
    access(1'b1, encoder_regs_pkg::ADDR_UNLOCK, stored, q, ok);
  endtask
endmodule // reg_host
`default_nettype wire

// [test/tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} row_t;
  logic mclk = 0, rst = 1, ok;
  logic regReq, regWrite, regAck, cmdValid, openAccess, eepromCmdAllowed, engineHalt;
  logic [7:0] regAddr, regWdata, regRdata, cmdCode, q;
  logic absReinitDone = 0, softRestartDone = 0, noniusClip = 0, noniusLowLevel = 0;
  logic masterClip = 0, masterLowLevel = 0, quadratureOverspeed = 0, converterOverspeed = 0;
  logic startupBusFault = 0, checksumFault = 0, eepromFault = 0, commandRunning = 0;
  logic turnLinkActive = 0, turnCommFail = 0, turnSsiError = 0, turnReadStart = 0;
  logic turnLastClock = 0, turnDataLine = 1, turnCountMismatch = 0, periodCountMismatch = 0;
  logic [1:0] lvl [3] = '{2'h2, 2'h3, 2'h1};
  int mismatches = 0, comparisons = 0, cycles = 0;
  // writes carry data, reads carry the expected byte
  row_t rows [8] = '{'{1'b1, 8'h60, 8'hA5}, '{1'b0, 8'h60, 8'hA5}, '{1'b1, 8'h40, 8'h3C},
    '{1'b0, 8'h40, 8'h3C}, '{1'b1, 8'h10, 8'h11}, '{1'b0, 8'h10, 8'h11},
    '{1'b0, 8'h76, 8'h00}, '{1'b0, 8'h77, 8'h00}};
  register_protect_and_status dut (.*);
  reg_host host (.*);
  initial begin
    forever #25 mclk = ~mclk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q, ok);
    check("write ack", 8'h01, 8'(ok));
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.access(1'b0, a, 8'h00, q, ok);
    check("read ack", 8'h01, 8'(ok));
    check($sformatf("read %h", a), e, q);
  endtask
  // data line passes the synchroniser before the read start or last clock pulse
  task automatic turn_pulse(input logic line, input logic start, input logic [7:0] e);
    turnDataLine = line;
    repeat (3) @(negedge mclk);
    turnReadStart = start;
    turnLastClock = !start;
    @(negedge mclk);
    turnReadStart = 0;
    turnLastClock = 0;
    rd(8'h77, e);
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    rst = 0;
    check("open", 8'h01, 8'(openAccess));
    check("halt", 8'h00, 8'(engineHalt));
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].d);
    end
    foreach (lvl[i]) begin
      wr(8'h17, {lvl[i], 6'h05});
      // access flags follow the stored level one cycle later
      @(negedge mclk);
      check("open", 8'h00, 8'(openAccess));
      check("busOk", 8'(lvl[i] == 2'h2), 8'(eepromCmdAllowed));
      wr(8'h10, 8'h77);
      rd(8'h10, 8'h00);
      wr(8'h40, 8'h00);
      rd(8'h40, 8'h3C);
      wr(8'h61, 8'h5A);
      rd(8'h61, 8'h5A);
      wr(8'h75, 8'h0A);
      check("cmdValid", 8'(lvl[i] == 2'h2), 8'(cmdValid));
      host.unlock(8'h00, ok);
      check("open", 8'h00, 8'(openAccess));
      host.unlock({lvl[i], 6'h05}, ok);
      @(negedge mclk);
      check("open", 8'(lvl[i] != 2'h1), 8'(openAccess));
      rd(8'h17, lvl[i] == 2'h1 ? 8'h00 : 8'h05);
    end
    rst = 1;
    repeat (2) @(negedge mclk);
    rst = 0;
    check("open", 8'h01, 8'(openAccess));
    wr(8'h75, 8'h03);
    check("cmdCode", 8'h03, cmdCode);
    wr(8'h75, 8'h07);
    check("cmdCode", 8'h07, cmdCode);
    wr(8'h0D, 8'h80);
    masterClip = 1;
    @(negedge mclk);
    masterClip = 0;
    rd(8'h76, 8'h02);
    rd(8'h76, 8'h00);
    noniusClip = 1;
    converterOverspeed = 1;
    @(negedge mclk);
    noniusClip = 0;
    converterOverspeed = 0;
    rd(8'h3D, 8'h00);
    rd(8'h76, 8'h00);
    rd(8'h77, 8'h00);
    quadratureOverspeed = 1;
    @(negedge mclk);
    quadratureOverspeed = 0;
    absReinitDone = 1;
    @(negedge mclk);
    absReinitDone = 0;
    rd(8'h77, 8'h00);
    periodCountMismatch = 1;
    rd(8'h77, 8'h08);
    periodCountMismatch = 0;
    rd(8'h77, 8'h08);
    eepromFault = 1;
    commandRunning = 1;
    rd(8'h77, 8'h41);
    eepromFault = 0;
    commandRunning = 0;
    rd(8'h77, 8'h00);
    wr(8'h0D, 8'h00);
    masterClip = 1;
    noniusLowLevel = 1;
    rd(8'h76, 8'h06);
    masterClip = 0;
    noniusLowLevel = 0;
    rd(8'h76, 8'h00);
    startupBusFault = 1;
    @(negedge mclk);
    startupBusFault = 0;
    @(negedge mclk);
    check("halt", 8'h01, 8'(engineHalt));
    rd(8'h76, 8'h10);
    absReinitDone = 1;
    @(negedge mclk);
    absReinitDone = 0;
    @(negedge mclk);
    check("halt", 8'h00, 8'(engineHalt));
    wr(8'h0E, 8'h05);
    turnSsiError = 1;
    rd(8'h77, 8'h20);
    turnSsiError = 0;
    masterLowLevel = 1;
    @(negedge mclk);
    check("halt", 8'h01, 8'(engineHalt));
    rd(8'h76, 8'h11);
    masterLowLevel = 0;
    @(negedge mclk);
    check("halt", 8'h00, 8'(engineHalt));
    turn_pulse(1'b1, 1'b1, 8'h00);
    turn_pulse(1'b0, 1'b1, 8'h20);
    turn_pulse(1'b1, 1'b1, 8'h00);
    turn_pulse(1'b1, 1'b0, 8'h20);
    turn_pulse(1'b1, 1'b1, 8'h00);
    turnLinkActive = 1;
    turnCommFail = 1;
    rd(8'h76, 8'h10);
    turnCommFail = 0;
    turnLinkActive = 0;
    rd(8'h76, 8'h00);
    checksumFault = 1;
    turnCountMismatch = 1;
    rd(8'h77, 8'h90);
    checksumFault = 0;
    turnCountMismatch = 0;
    wr(8'h0D, 8'h80);
    checksumFault = 1;
    @(negedge mclk);
    checksumFault = 0;
    softRestartDone = 1;
    @(negedge mclk);
    softRestartDone = 0;
    rd(8'h77, 8'h00);
    results();
  end
endmodule // tb_top
`default_nettype wire
